// ---- common/usb_fctl_pkg.sv ----
// package of constants and carriers for the usb function control and frame number registers
// Notes on behaviour
// - connect bit high drives pull-up output enabled; low leaves it high impedance.
// - connect bit survives usb bus reset; only software writes change it.
// - respond-enable low makes the buffer manager ignore all usb transactions.
// - usb bus reset clears respond-enable.
// - wake request bit drives resume signalling upstream to leave suspend.
// - with propagate set, bus reset resets all logic except shadow, connect, propagate, confirm.
// - with propagate set, bus reset also asserts the reset output pin.
// - confirm bit set before shadow clear for boot mode; kept over bus reset.
// - 11-bit frame number read as two bytes; low byte holds bits 7:0.
// - high byte carries bits 10:8 in 2:0; bits 7:3 read zero.
// - each start-of-frame packet loads its frame number field.
// - while unlocked, each pseudo frame start increments the frame number.
// - pseudo frame starts every nominal 1 ms while frame timer unlocked.
package usb_fctl_pkg;
  localparam logic [15:0] ADDR_FRAME_HIGH = 16'hfffa;
  localparam logic [15:0] ADDR_FRAME_LOW = 16'hfffb;
  localparam logic [15:0] ADDR_CONTROL = 16'hfffc;
  localparam logic [15:0] ADDR_MEMORY_CONFIGURATION = 16'hfff8;
  localparam int BIT_CONNECT = 7;
  localparam int BIT_RESPOND = 6;
  localparam int BIT_WAKE = 5;
  localparam int BIT_PROPAGATE = 4;
  localparam int BIT_CONFIRM = 0;
  localparam int BIT_SHADOW = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hf1;
  localparam logic [7:0] MEMORY_CONFIGURATION_RESET = 8'h01;
  localparam logic [10:0] FRAME_RESET = 11'h000;
  localparam logic [10:0] FRAME_ONE = 11'h001;
  localparam int CLK_MHZ = 40;
  localparam int FRAME_PERIOD_US = 1000;
  localparam int FRAME_CYCLES = FRAME_PERIOD_US * CLK_MHZ;
  localparam logic [15:0] FRAME_TIMER_ZERO = 16'h0000;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [10:0] number;
  } sof_in_t;
endpackage

// ---- verilog/pseudo_frame_timer.sv ----
// free running 1 ms frame timer producing pseudo frame start pulses when unlocked
`timescale 1ns/100ps
module pseudo_frame_timer #(
  parameter logic [15:0] PERIOD = 16'(usb_fctl_pkg::FRAME_CYCLES)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic restart,
  input wire logic locked,
  output logic pulse
);
  logic [15:0] count_r;

  // any real start-of-frame restarts the interval so pseudo frames fill gaps only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_r <= usb_fctl_pkg::FRAME_TIMER_ZERO;
      pulse <= 1'b0;
    end else if (clk_en) begin
      pulse <= 1'b0;
      if (restart || count_r == PERIOD - 16'h0001) begin
        count_r <= usb_fctl_pkg::FRAME_TIMER_ZERO;
        pulse <= !restart && !locked;
      end else begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

  a_pulse_unlocked: assert property (@(posedge clk_sys) disable iff (reset)
    pulse && $past(clk_en) |-> $past(!locked && !restart)) else $error("pseudo frame while locked");
endmodule // pseudo_frame_timer

// ---- verilog/usb_function_control_frame_number.sv ----
// control register and frame number registers of the usb function controller
`timescale 1ns/100ps
module usb_function_control_frame_number #(
  parameter logic [15:0] FRAME_PERIOD = 16'(usb_fctl_pkg::FRAME_CYCLES)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire usb_fctl_pkg::reg_req_t req,
  input wire logic usb_bus_reset,
  input wire usb_fctl_pkg::sof_in_t sof,
  input wire logic frame_locked,
  output logic [7:0] rdata,
  output logic dplus_pullup_drive_oe,
  output logic respond_enable,
  output logic resume_request,
  output logic reset_output_pin,
  output logic internal_reset,
  output logic shadow_select,
  output logic pseudo_frame_start
);
  logic connect_r;
  logic respond_r;
  logic wake_r;
  logic propagate_r;
  logic confirm_r;
  logic shadow_r;
  logic [10:0] frame_count_r;
  logic [7:0] rdata_nxt;
  logic wr_ctl;
  logic wr_mem;
  logic pseudo_pulse;
  logic full_reset;

  // -------------------------------------------------------------
  // register decode
  // -------------------------------------------------------------
  function automatic logic hit(input usb_fctl_pkg::reg_req_t r, input logic [15:0] a);
    hit = r.sel && r.wr && r.addr == a;
  endfunction

  // control byte as software sees it; reserved bits always read low
  function automatic logic [7:0] ctl_image(
    input logic connect,
    input logic respond,
    input logic wake,
    input logic propagate,
    input logic confirm
  );
    ctl_image = 8'h00;
    ctl_image[usb_fctl_pkg::BIT_CONNECT] = connect;
    ctl_image[usb_fctl_pkg::BIT_RESPOND] = respond;
    ctl_image[usb_fctl_pkg::BIT_WAKE] = wake;
    ctl_image[usb_fctl_pkg::BIT_PROPAGATE] = propagate;
    ctl_image[usb_fctl_pkg::BIT_CONFIRM] = confirm;
  endfunction

  // top three frame bits in the low positions, the rest reserved
  function automatic logic [7:0] frame_high_image(input logic [10:0] n);
    frame_high_image = {5'h00, n[10:8]};
  endfunction

  assign wr_ctl = hit(req, usb_fctl_pkg::ADDR_CONTROL);
  assign wr_mem = hit(req, usb_fctl_pkg::ADDR_MEMORY_CONFIGURATION);
  // with propagate set, bus reset clears wake, the frame count and the timer
  assign full_reset = usb_bus_reset && propagate_r;

  // -------------------------------------------------------------
  // exempt control bits: only power-on reset or software change them
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      connect_r <= 1'b0;
      propagate_r <= 1'b0;
    end else if (clk_en && wr_ctl) begin
      connect_r <= req.wdata[usb_fctl_pkg::BIT_CONNECT];
      propagate_r <= req.wdata[usb_fctl_pkg::BIT_PROPAGATE];
    end
  end

  // confirm is kept through bus resets
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      confirm_r <= 1'b0;
    end else if (clk_en && wr_ctl) begin
      confirm_r <= req.wdata[usb_fctl_pkg::BIT_CONFIRM];
    end
  end

  // shadow select: clearing needs confirm, setting is free
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shadow_r <= usb_fctl_pkg::MEMORY_CONFIGURATION_RESET[usb_fctl_pkg::BIT_SHADOW];
    end else if (clk_en && wr_mem) begin
      if (req.wdata[usb_fctl_pkg::BIT_SHADOW] || confirm_r) begin
        shadow_r <= req.wdata[usb_fctl_pkg::BIT_SHADOW];
      end
    end
  end

  // -------------------------------------------------------------
  // bus-reset sensitive control bits
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      respond_r <= 1'b0;
    end else if (clk_en) begin
      if (usb_bus_reset) begin
        respond_r <= 1'b0;
      end else if (wr_ctl) begin
        respond_r <= req.wdata[usb_fctl_pkg::BIT_RESPOND];
      end
    end
  end

  // wake is cleared by software or a propagated bus reset; firmware must drop it within 2.5 us
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wake_r <= 1'b0;
    end else if (clk_en) begin
      if (full_reset) begin
        wake_r <= 1'b0;
      end else if (wr_ctl) begin
        wake_r <= req.wdata[usb_fctl_pkg::BIT_WAKE];
      end
    end
  end

  // -------------------------------------------------------------
  // frame number
  // -------------------------------------------------------------
  pseudo_frame_timer #(
    .PERIOD(FRAME_PERIOD)
  ) u_timer (
    .clk_sys(clk_sys),
    // bus reset only acts while enabled, so a frozen block keeps its timer
    .reset(reset || (clk_en && full_reset)),
    .clk_en(clk_en),
    .restart(sof.valid),
    .locked(frame_locked),
    .pulse(pseudo_pulse)
  );

  // a real packet wins over a pseudo pulse in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      frame_count_r <= usb_fctl_pkg::FRAME_RESET;
    end else if (clk_en) begin
      if (full_reset) begin
        frame_count_r <= usb_fctl_pkg::FRAME_RESET;
      end else if (sof.valid) begin
        frame_count_r <= sof.number;
      end else if (pseudo_pulse && !frame_locked) begin
        frame_count_r <= frame_count_r + usb_fctl_pkg::FRAME_ONE;
      end
    end
  end

  // -------------------------------------------------------------
  // read data and registered outputs
  // -------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (req.sel && !req.wr) begin
      unique case (req.addr)
        usb_fctl_pkg::ADDR_FRAME_LOW: rdata_nxt = frame_count_r[7:0];
        usb_fctl_pkg::ADDR_FRAME_HIGH: rdata_nxt = frame_high_image(frame_count_r);
        usb_fctl_pkg::ADDR_CONTROL: rdata_nxt = ctl_image(connect_r, respond_r, wake_r, propagate_r, confirm_r);
        usb_fctl_pkg::ADDR_MEMORY_CONFIGURATION: rdata_nxt = {7'h00, shadow_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata <= 8'h00;
      dplus_pullup_drive_oe <= 1'b0;
      respond_enable <= 1'b0;
      resume_request <= 1'b0;
      reset_output_pin <= 1'b0;
      internal_reset <= 1'b0;
      shadow_select <= usb_fctl_pkg::MEMORY_CONFIGURATION_RESET[usb_fctl_pkg::BIT_SHADOW];
      pseudo_frame_start <= 1'b0;
    end else if (clk_en) begin
      rdata <= rdata_nxt;
      dplus_pullup_drive_oe <= connect_r;
      respond_enable <= respond_r;
      resume_request <= wake_r;
      reset_output_pin <= full_reset;
      internal_reset <= full_reset;
      shadow_select <= shadow_r;
      pseudo_frame_start <= pseudo_pulse;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_pullup_follows: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && $past(clk_en) |-> dplus_pullup_drive_oe == $past(connect_r)) else $error("pull-up mismatch");
  a_connect_kept: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && usb_bus_reset && !wr_ctl |=> connect_r == $past(connect_r)) else $error("connect lost");
  a_respond_clear: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && usb_bus_reset |=> !respond_r) else $error("respond not cleared");
  a_resume_drive: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && wr_ctl && req.wdata[usb_fctl_pkg::BIT_WAKE] && !full_reset ##1 clk_en |=> resume_request)
    else $error("no resume");
  a_rst_pin: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && usb_bus_reset && propagate_r |=> reset_output_pin) else $error("reset pin idle");
  a_shadow_guard: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && wr_mem && !confirm_r && shadow_r |=> shadow_r) else $error("shadow cleared unconfirmed");
  a_frame_load: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && sof.valid && !full_reset |=> frame_count_r == $past(sof.number)) else $error("frame not loaded");
  a_frame_incr: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && pseudo_pulse && !sof.valid && !frame_locked && !full_reset
    |=> frame_count_r == $past(frame_count_r) + usb_fctl_pkg::FRAME_ONE) else $error("frame not incremented");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset)
    rdata_nxt[7:3] == 5'h00 || req.addr != usb_fctl_pkg::ADDR_FRAME_HIGH) else $error("reserved nonzero");

  // -------------------------------------------------------------
  // software writes land in the next cycle
  // -------------------------------------------------------------
  a_connect_write: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && wr_ctl
    |=> connect_r == $past(req.wdata[usb_fctl_pkg::BIT_CONNECT])) else $error("connect write lost");
  a_respond_write: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && wr_ctl && !usb_bus_reset
    |=> respond_r == $past(req.wdata[usb_fctl_pkg::BIT_RESPOND])) else $error("respond write lost");
  a_wake_write: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && wr_ctl && !full_reset
    |=> wake_r == $past(req.wdata[usb_fctl_pkg::BIT_WAKE])) else $error("wake write lost");
  a_shadow_set: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && wr_mem && (req.wdata[usb_fctl_pkg::BIT_SHADOW] || confirm_r)
    |=> shadow_r == $past(req.wdata[usb_fctl_pkg::BIT_SHADOW])) else $error("shadow write lost");

  // -------------------------------------------------------------
  // registered outputs follow their sources by one enabled edge
  // -------------------------------------------------------------
  a_respond_follows: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en |=> respond_enable == $past(respond_r)) else $error("respond output stale");
  a_resume_follows: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en |=> resume_request == $past(wake_r)) else $error("resume output stale");
  a_internal_rst: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en |=> internal_reset == $past(full_reset)) else $error("internal reset mismatch");
  a_rst_pin_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && !full_reset |=> !reset_output_pin) else $error("reset pin without cause");
  a_shadow_out: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en |=> shadow_select == $past(shadow_r)) else $error("shadow output stale");
  a_pseudo_out: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en |=> pseudo_frame_start == $past(pseudo_pulse)) else $error("pseudo output stale");

  // -------------------------------------------------------------
  // bus reset: what it clears and what it must keep
  // -------------------------------------------------------------
  a_wake_clear: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && full_reset |=> !wake_r) else $error("wake survived bus reset");
  a_frame_reset: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && full_reset |=> frame_count_r == usb_fctl_pkg::FRAME_RESET) else $error("frame survived bus reset");
  a_propagate_kept: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && usb_bus_reset && !wr_ctl
    |=> propagate_r == $past(propagate_r)) else $error("propagate lost");
  a_shadow_kept: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && usb_bus_reset && !wr_mem
    |=> shadow_r == $past(shadow_r)) else $error("shadow lost");
  a_confirm_kept: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && usb_bus_reset && !wr_ctl
    |=> confirm_r == $past(confirm_r)) else $error("confirm lost");

  // -------------------------------------------------------------
  // read data and frame number behaviour
  // -------------------------------------------------------------
  a_ctl_reserved: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && req.sel && !req.wr && req.addr == usb_fctl_pkg::ADDR_CONTROL
    |=> rdata[usb_fctl_pkg::BIT_PROPAGATE - 1:usb_fctl_pkg::BIT_CONFIRM + 1] == 3'h0)
    else $error("reserved control bits set");
  a_low_byte: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && req.sel && !req.wr && req.addr == usb_fctl_pkg::ADDR_FRAME_LOW
    |=> rdata == $past(frame_count_r[7:0])) else $error("low frame byte wrong");
  a_high_byte: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && req.sel && !req.wr && req.addr == usb_fctl_pkg::ADDR_FRAME_HIGH
    |=> rdata == {5'h00, $past(frame_count_r[10:8])}) else $error("high frame byte wrong");
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && !(req.sel && !req.wr) |=> rdata == 8'h00) else $error("read data without read");
  a_frame_hold: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && !sof.valid && !pseudo_pulse && !full_reset
    |=> $stable(frame_count_r)) else $error("frame moved without cause");
  a_frame_locked: assert property (@(posedge clk_sys) disable iff (reset)
    clk_en && frame_locked && !sof.valid && !full_reset
    |=> $stable(frame_count_r)) else $error("frame moved while locked");

  // -------------------------------------------------------------
  // freeze: a low clock enable holds every register and output
  // -------------------------------------------------------------
  a_freeze_ctl: assert property (@(posedge clk_sys) disable iff (reset)
    !clk_en |=> $stable(connect_r) && $stable(respond_r) && $stable(wake_r)
    && $stable(propagate_r) && $stable(confirm_r) && $stable(shadow_r))
    else $error("control moved while frozen");
  a_freeze_frame: assert property (@(posedge clk_sys) disable iff (reset)
    !clk_en |=> $stable(frame_count_r)) else $error("frame moved while frozen");
  a_freeze_out: assert property (@(posedge clk_sys) disable iff (reset)
    !clk_en |=> $stable(rdata) && $stable(dplus_pullup_drive_oe) && $stable(reset_output_pin)
    && $stable(internal_reset) && $stable(pseudo_frame_start) && $stable(shadow_select))
    else $error("output moved while frozen");
endmodule // usb_function_control_frame_number

// ---- bench/usb_host_model.sv ----
// upstream host model: start-of-frame packets and bus reset
`timescale 1ns/100ps
module usb_host_model (
  input wire logic clk_sys,
  input wire logic send,
  input wire logic [10:0] num,
  input wire logic hold_reset,
  output usb_fctl_pkg::sof_in_t sof,
  output logic usb_bus_reset
);
  logic [10:0] pat_r = 11'h2aa;
  // off-frame field changes every cycle so a stale number never looks fresh
  always @(posedge clk_sys) pat_r <= ~pat_r;
  assign sof.valid = send;
  assign sof.number = send ? num : pat_r;
  assign usb_bus_reset = hold_reset;
endmodule // usb_host_model

// ---- bench/usb_function_control_frame_number_tb.sv ----
// self-checking bench for the control and frame number registers
`timescale 1ns/100ps
module usb_function_control_frame_number_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic locked = 1'b1;
  logic send = 1'b0;
  logic hold_reset = 1'b0;
  logic [10:0] num = 11'h000;
  logic [10:0] n;
  logic [7:0] rd_v;
  usb_fctl_pkg::reg_req_t req = '0;
  usb_fctl_pkg::sof_in_t sof;
  logic bus_rst, dp_oe, resp, resume, rst_pin, int_rst, shadow, pseudo;
  logic [7:0] rdata;
  int fails = 0;
  int n_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  usb_host_model host_u (.clk_sys(clk_sys), .send(send), .num(num), .hold_reset(hold_reset),
    .sof(sof), .usb_bus_reset(bus_rst));
  usb_function_control_frame_number #(.FRAME_PERIOD(16'h0010)) dut_u (.clk_sys(clk_sys),
    .reset(reset), .clk_en(clk_en), .req(req), .usb_bus_reset(bus_rst), .sof(sof),
    .frame_locked(locked), .rdata(rdata), .dplus_pullup_drive_oe(dp_oe), .respond_enable(resp),
    .resume_request(resume), .reset_output_pin(rst_pin), .internal_reset(int_rst),
    .shadow_select(shadow), .pseudo_frame_start(pseudo));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] ctl_exp(input logic [7:0] d, input logic brst);
    return brst ? (d & 8'h90 & usb_fctl_pkg::CONTROL_WRITE_MASK) | (d & 8'h01)
      : d & usb_fctl_pkg::CONTROL_WRITE_MASK;
  endfunction
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t rdata=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req = '{sel: 1'b1, wr: w, addr: a, wdata: d};
    @(negedge clk_sys);
    req = '0;
    rd_v = rdata;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk_rd(rd_v, e);
  endtask
  task automatic rd_fn(input logic [10:0] e);
    rd(usb_fctl_pkg::ADDR_FRAME_LOW, e[7:0]);
    rd(usb_fctl_pkg::ADDR_FRAME_HIGH, {5'h00, e[10:8]});
  endtask
  task automatic frame(input logic [10:0] v);
    @(negedge clk_sys);
    send = 1'b1;
    num = v;
    @(negedge clk_sys);
    send = 1'b0;
  endtask
  task automatic bus_reset(input logic exp_pin);
    @(negedge clk_sys);
    hold_reset = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(rst_pin, exp_pin);
    chk(int_rst, exp_pin);
    hold_reset = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic end_of_test;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wait_pseudo;
    int i;
    i = 0;
    while (pseudo !== 1'b1 && i < 100) begin
      @(negedge clk_sys);
      i++;
    end
    if (i == 100) begin
      fails++;
      end_of_test();
    end
    @(negedge clk_sys);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(77));
    repeat (8) @(negedge clk_sys);
    reset = 1'b0;
    chk(shadow, 1'b1);
    rd(usb_fctl_pkg::ADDR_CONTROL, usb_fctl_pkg::CONTROL_RESET);
    rd_fn(usb_fctl_pkg::FRAME_RESET);
    acc(1'b1, usb_fctl_pkg::ADDR_MEMORY_CONFIGURATION, 8'h00);
    chk(shadow, 1'b1);
    acc(1'b1, usb_fctl_pkg::ADDR_CONTROL, 8'hff);
    chk({dp_oe, resp, resume}, 3'b111);
    rd(usb_fctl_pkg::ADDR_CONTROL, ctl_exp(8'hff, 1'b0));
    // wake bit dropped well inside the resume window
    acc(1'b1, usb_fctl_pkg::ADDR_CONTROL, 8'hc0);
    chk({resume, resp}, 2'b01);
    bus_reset(1'b0);
    chk({dp_oe, resp}, 2'b10);
    rd(usb_fctl_pkg::ADDR_CONTROL, 8'h80);
    acc(1'b1, usb_fctl_pkg::ADDR_CONTROL, 8'hf1);
    for (int k = 0; k < 6; k++) begin
      n = (k == 0) ? 11'h7ff : 11'($urandom());
      frame(n);
      rd_fn(n);
    end
    acc(1'b1, usb_fctl_pkg::ADDR_FRAME_LOW, ~n[7:0]);
    rd_fn(n);
    rd(16'h1234, 8'h00);
    bus_reset(1'b1);
    rd(usb_fctl_pkg::ADDR_CONTROL, ctl_exp(8'hf1, 1'b1));
    chk({shadow, dp_oe, resp}, 3'b110);
    rd_fn(usb_fctl_pkg::FRAME_RESET);
    // frozen enable: a write and a frame packet must leave everything alone
    clk_en = 1'b0;
    acc(1'b1, usb_fctl_pkg::ADDR_CONTROL, 8'h00);
    frame(11'h3c5);
    chk({dp_oe, shadow}, 2'b11);
    clk_en = 1'b1;
    rd(usb_fctl_pkg::ADDR_CONTROL, ctl_exp(8'hf1, 1'b1));
    rd_fn(usb_fctl_pkg::FRAME_RESET);
    frame(11'h7fe);
    locked = 1'b0;
    wait_pseudo();
    rd_fn(11'h7ff);
    wait_pseudo();
    rd_fn(11'h000);
    locked = 1'b1;
    frame(11'h123);
    repeat (40) @(negedge clk_sys);
    rd_fn(11'h123);
    acc(1'b1, usb_fctl_pkg::ADDR_MEMORY_CONFIGURATION, 8'h00);
    chk(shadow, 1'b0);
    end_of_test();
  end
endmodule // usb_function_control_frame_number_tb
